//--- rtl/imups_pkg.sv
// imups package: register map, frame layout, timing and carrier types
package imups_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses within a page)
	// ----------------------------------------------------------------
	localparam logic [6:0] IMUPS_OFS_PAGE_SELECT  = 7'h00;
	localparam logic [6:0] IMUPS_OFS_TEMPERATURE  = 7'h0E;
	localparam logic [6:0] IMUPS_OFS_X_RATE_LOW   = 7'h10;
	localparam logic [6:0] IMUPS_OFS_X_RATE_HIGH  = 7'h12;
	localparam logic [6:0] IMUPS_OFS_Y_RATE_LOW   = 7'h14;
	localparam logic [6:0] IMUPS_OFS_Y_RATE_HIGH  = 7'h16;
	localparam logic [6:0] IMUPS_OFS_Z_RATE_LOW   = 7'h18;
	localparam logic [6:0] IMUPS_OFS_Z_RATE_HIGH  = 7'h1A;
	localparam logic [6:0] IMUPS_OFS_X_ACCEL_LOW  = 7'h1C;
	localparam logic [6:0] IMUPS_OFS_X_ACCEL_HIGH = 7'h1E;
	localparam logic [6:0] IMUPS_OFS_Y_ACCEL_LOW  = 7'h20;
	localparam logic [6:0] IMUPS_OFS_Y_ACCEL_HIGH = 7'h22;
	localparam logic [6:0] IMUPS_OFS_Z_ACCEL_LOW  = 7'h24;
	localparam logic [6:0] IMUPS_OFS_Z_ACCEL_HIGH = 7'h26;
	localparam logic [6:0] IMUPS_OFS_X_FIELD      = 7'h28;
	localparam logic [6:0] IMUPS_OFS_Y_FIELD      = 7'h2A;
	localparam logic [6:0] IMUPS_OFS_Z_FIELD      = 7'h2C;
	localparam logic [6:0] IMUPS_OFS_PRESS_LOW    = 7'h2E;
	localparam logic [6:0] IMUPS_OFS_PRESS_HIGH   = 7'h30;
	localparam logic [6:0] IMUPS_OFS_PIN_FUNC     = 7'h06;
	localparam logic [6:0] IMUPS_OFS_PIN_GEN      = 7'h08;
	localparam logic [6:0] IMUPS_OFS_SERIAL       = 7'h20;

	// pages
	localparam logic [7:0] IMUPS_PAGE_DATA   = 8'h00;
	localparam logic [7:0] IMUPS_PAGE_PINS   = 8'h03;
	localparam logic [7:0] IMUPS_PAGE_SERIAL = 8'h04;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  IMUPS_RST_PAGE     = 8'h00;
	localparam logic [15:0] IMUPS_RST_PIN_FUNC = 16'h000D;
	localparam logic [15:0] IMUPS_RST_PIN_GEN  = 16'h0000;
	// arbitrary serial number value
	localparam logic [15:0] IMUPS_SERIAL_VALUE = 16'h1234;

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int IMUPS_FRAME_BITS  = 16;
	localparam int IMUPS_BIT_WRITE   = 15;
	localparam int IMUPS_ADDR_MSB    = 14;
	localparam int IMUPS_ADDR_LSB    = 8;
	// pin_function_ctrl bit that routes data-ready onto general pin two
	localparam int IMUPS_PF_DR_EN    = 3;

	// ----------------------------------------------------------------
	// timing: startup initialisation delay
	// ----------------------------------------------------------------
	localparam int IMUPS_CLK_HZ      = 20000000;
	localparam int IMUPS_INIT_US     = 100;
	localparam int IMUPS_INIT_CYC    = (IMUPS_INIT_US * (IMUPS_CLK_HZ / 1000000));

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] x_rate;
		logic [31:0] y_rate;
		logic [31:0] z_rate;
		logic [31:0] x_accel;
		logic [31:0] y_accel;
		logic [31:0] z_accel;
		logic [15:0] x_field;
		logic [15:0] y_field;
		logic [15:0] z_field;
		logic [31:0] pressure;
		logic [15:0] temperature;
	} imups_sample_t;

	typedef struct packed {
		logic       is_write;
		logic [6:0] addr;
		logic [7:0] data;
	} imups_frame_t;

	typedef enum logic [1:0] {
		IMUPS_ST_INIT = 2'b00,
		IMUPS_ST_RUN  = 2'b01
	} imups_state_t;

endpackage : imups_pkg

//--- rtl/imups_port.sv
// imups top: paged SPI mode 3 register port of an inertial sensor
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - starts alone after reset, then keeps loading samples without host commands
// - by default the data-ready signal appears on general pin two
// - data-ready goes high when a new sample set is loaded
// - mode 3: clock idles high, data captured on rising edge
// - frames are 16 bits, MSB first, always all 16 clocks
// - a read takes two frames; data shifts out in the second
// - read request: bit 15 zero, address in upper byte, low byte ignored
// - new command is taken while the previous read result shifts out
// - request 0x1A00 returns the Z rate high word next frame
// - page 0 is selected after startup
// - writing 0x00 to the page register returns decoding to page 0
// - page 0 holds X, Y, Z rate low/high pairs at 0x10, 0x14, 0x18
// - page 0 holds X, Y, Z accel low/high pairs at 0x1C, 0x20, 0x24
// - page 0 temperature 0x0E, fields 0x28-0x2C, pressure 0x2E and 0x30
// - page 3 pin function control at 0x06, read/write, resets to 0x000D
// - page 3 general pin control at 0x08, read/write
module imups_port
	import imups_pkg::*;
#(
	parameter int INIT_CYCLES = IMUPS_INIT_CYC
) (
	// clock and reset
	input  wire logic            i_core_clk,
	input  wire logic            i_reset,
	// spi pins
	input  wire logic            i_spi_sclk,
	input  wire logic            i_spi_cs_n,
	input  wire logic            i_spi_mosi,
	output logic                 o_spi_miso,
	output logic                 o_spi_miso_oe,
	// sample source from sensor logic
	input  wire imups_sample_t   i_sample,
	input  wire logic            i_sample_valid,
	// general pin two
	output logic                 o_general_pin_two,
	output logic                 o_general_pin_two_oe,
	// status
	output logic                 o_ready,
	output logic [7:0]           o_page
);

	// ----------------------------------------------------------------
	// timing notes
	// ----------------------------------------------------------------
	// every pin passes two flops, clock and select an edge detector too, so the logic
	// sees each serial edge about three core clocks after the pin
	// the serial clock period must be at least eight core clocks: a
	// faster host loses miso timing margin long before any serial edge is lost
	// chip-select must stay high for one full core clock between frames,
	// or its falling edge may never reach the detector
	// the first reply bit goes out at chip-select fall; later bits
	// follow each falling serial edge, about three clocks late
	// a frame ends on its sixteenth rising edge; chip-select rising
	// earlier abandons the frame and the pending reply stays part shifted
	// writes land a few core clocks after the last rising edge, long
	// before a legal host can begin the next frame
	// a reply is only valid if no reset fell between the two frames

	// ----------------------------------------------------------------
	// pin synchronisers; mosi takes the same two flops as the clock
	// so that data and the edge that takes it stay aligned
	// ----------------------------------------------------------------
	logic sclk_s;
	logic cs_n_s;
	logic mosi_s;

	imups_sync u_sync_sclk (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_async    (i_spi_sclk),
		.o_sync     (sclk_s)
	);
	imups_sync u_sync_cs (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_async    (i_spi_cs_n),
		.o_sync     (cs_n_s)
	);
	imups_sync u_sync_mosi (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_async    (i_spi_mosi),
		.o_sync     (mosi_s)
	);

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	imups_state_t  state_r;
	logic [15:0]   init_cnt_r;
	imups_sample_t sample_r;
	logic          dr_r;
	logic          sclk_d_r;
	logic          cs_d_r;
	logic [15:0]   rx_r;
	logic [15:0]   tx_r;
	logic [4:0]    bit_cnt_r;
	logic [7:0]    page_r;
	logic [15:0]   pin_func_r;
	logic [15:0]   pin_gen_r;
	logic          miso_r;
	logic          miso_oe_r;

	// ----------------------------------------------------------------
	// edge detection on synced pins
	// ----------------------------------------------------------------
	wire sclk_rise  = sclk_s & ~sclk_d_r;
	wire sclk_fall  = ~sclk_s & sclk_d_r;
	wire cs_fall    = ~cs_n_s & cs_d_r;
	wire active     = ~cs_n_s;
	// 16th rising edge completes the frame
	wire [15:0] rx_word   = {rx_r[14:0], mosi_s};
	wire        frame_end = active & sclk_rise &
	                        (bit_cnt_r == 5'(IMUPS_FRAME_BITS - 1));
	imups_frame_t frame;
	assign frame.is_write = rx_word[IMUPS_BIT_WRITE];
	assign frame.addr     = rx_word[IMUPS_ADDR_MSB:IMUPS_ADDR_LSB];
	assign frame.data     = rx_word[7:0];

	// ----------------------------------------------------------------
	// read decode on the current page; word address has bit 0 dropped
	// ----------------------------------------------------------------
	// the page register answers on every page, so a host that lands on
	// an unknown page can always find its way back; unmapped words
	// read as zero
	wire [6:0] ra = {frame.addr[6:1], 1'b0}; // data byte unused for reads
	wire pg0 = (page_r == IMUPS_PAGE_DATA);
	wire pg3 = (page_r == IMUPS_PAGE_PINS);
	wire pg4 = (page_r == IMUPS_PAGE_SERIAL);
	logic [15:0] rd_data;
	always_comb begin
		rd_data = 16'h0000;
		if (ra == IMUPS_OFS_PAGE_SELECT) begin
			rd_data = {8'h00, page_r};
		end else if (pg0 && ra == IMUPS_OFS_TEMPERATURE) begin
			rd_data = sample_r.temperature;
		end else if (pg0 && ra == IMUPS_OFS_X_RATE_LOW) begin
			rd_data = sample_r.x_rate[15:0];
		end else if (pg0 && ra == IMUPS_OFS_X_RATE_HIGH) begin
			rd_data = sample_r.x_rate[31:16];
		end else if (pg0 && ra == IMUPS_OFS_Y_RATE_LOW) begin
			rd_data = sample_r.y_rate[15:0];
		end else if (pg0 && ra == IMUPS_OFS_Y_RATE_HIGH) begin
			rd_data = sample_r.y_rate[31:16];
		end else if (pg0 && ra == IMUPS_OFS_Z_RATE_LOW) begin
			rd_data = sample_r.z_rate[15:0];
		end else if (pg0 && ra == IMUPS_OFS_Z_RATE_HIGH) begin
			rd_data = sample_r.z_rate[31:16];
		end else if (pg0 && ra == IMUPS_OFS_X_ACCEL_LOW) begin
			rd_data = sample_r.x_accel[15:0];
		end else if (pg0 && ra == IMUPS_OFS_X_ACCEL_HIGH) begin
			rd_data = sample_r.x_accel[31:16];
		end else if (pg0 && ra == IMUPS_OFS_Y_ACCEL_LOW) begin
			rd_data = sample_r.y_accel[15:0];
		end else if (pg0 && ra == IMUPS_OFS_Y_ACCEL_HIGH) begin
			rd_data = sample_r.y_accel[31:16];
		end else if (pg0 && ra == IMUPS_OFS_Z_ACCEL_LOW) begin
			rd_data = sample_r.z_accel[15:0];
		end else if (pg0 && ra == IMUPS_OFS_Z_ACCEL_HIGH) begin
			rd_data = sample_r.z_accel[31:16];
		end else if (pg0 && ra == IMUPS_OFS_X_FIELD) begin
			rd_data = sample_r.x_field;
		end else if (pg0 && ra == IMUPS_OFS_Y_FIELD) begin
			rd_data = sample_r.y_field;
		end else if (pg0 && ra == IMUPS_OFS_Z_FIELD) begin
			rd_data = sample_r.z_field;
		end else if (pg0 && ra == IMUPS_OFS_PRESS_LOW) begin
			rd_data = sample_r.pressure[15:0];
		end else if (pg0 && ra == IMUPS_OFS_PRESS_HIGH) begin
			rd_data = sample_r.pressure[31:16];
		end else if (pg3 && ra == IMUPS_OFS_PIN_FUNC) begin
			rd_data = pin_func_r;
		end else if (pg3 && ra == IMUPS_OFS_PIN_GEN) begin
			rd_data = pin_gen_r;
		end else if (pg4 && ra == IMUPS_OFS_SERIAL) begin
			rd_data = IMUPS_SERIAL_VALUE;
		end
	end

	// ----------------------------------------------------------------
	// write decode: odd address hits the upper byte
	// ----------------------------------------------------------------
	// the page register has no upper byte: an odd-address write to it
	// is dropped rather than folded onto the page number
	wire wr_en     = frame_end & frame.is_write;
	wire wr_hi     = frame.addr[0];
	wire wr_page   = wr_en & (ra == IMUPS_OFS_PAGE_SELECT) & ~wr_hi;
	wire wr_pfunc  = wr_en & pg3 & (ra == IMUPS_OFS_PIN_FUNC);
	wire wr_pgen   = wr_en & pg3 & (ra == IMUPS_OFS_PIN_GEN);
	wire [15:0] pfunc_nxt = wr_hi ? {frame.data, pin_func_r[7:0]}
	                              : {pin_func_r[15:8], frame.data};
	wire [15:0] pgen_nxt  = wr_hi ? {frame.data, pin_gen_r[7:0]}
	                              : {pin_gen_r[15:8], frame.data};

	// ----------------------------------------------------------------
	// startup sequencer; no host command needed to begin sampling
	// ----------------------------------------------------------------
	// INIT_CYCLES must fit the 16-bit counter; a larger value is cut
	// and startup would end early
	wire init_done = (init_cnt_r == 16'(INIT_CYCLES - 1));
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_r    <= IMUPS_ST_INIT;
			init_cnt_r <= 16'h0000;
		end else begin
			case (state_r)
				IMUPS_ST_INIT: begin
					init_cnt_r <= init_cnt_r + 16'h0001;
					if (init_done) begin
						state_r <= IMUPS_ST_RUN;
					end
				end
				default: begin
					state_r <= IMUPS_ST_RUN;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sample load and data-ready pulse; loads are not held off during a
	// read, so a low/high word pair may span two sample sets, traded for
	// a sensor side that never waits on the host
	// ----------------------------------------------------------------
	wire load = (state_r == IMUPS_ST_RUN) & i_sample_valid;
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			sample_r <= '0;
			dr_r     <= 1'b0;
		end else begin
			if (load) begin
				sample_r <= i_sample;
			end
			dr_r <= load;
		end
	end

	// ----------------------------------------------------------------
	// spi shift engine: sample on rising, drive on falling edge
	// ----------------------------------------------------------------
	// reply chosen at frame end: a write answers with zero
	wire [15:0] reply_word = frame.is_write ? 16'h0000 : rd_data;
	wire [15:0] tx_shift   = {tx_r[14:0], 1'b0};
	wire        bit_take   = active & sclk_rise;
	wire        bit_give   = active & sclk_fall;

	// edge detector history, reset to the idle pin levels
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			sclk_d_r <= 1'b1;
			cs_d_r   <= 1'b1;
		end else begin
			sclk_d_r <= sclk_s;
			cs_d_r   <= cs_n_s;
		end
	end

	// receive side: bit counter restarts at every chip-select fall
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			rx_r      <= 16'h0000;
			bit_cnt_r <= 5'h00;
		end else if (cs_fall) begin
			bit_cnt_r <= 5'h00;
		end else if (bit_take) begin
			rx_r      <= rx_word;
			bit_cnt_r <= frame_end ? 5'h00 : bit_cnt_r + 5'h01;
		end
	end

	// transmit side: reply loaded as its own command is taken, then shifted out in the next frame
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			tx_r <= 16'h0000;
		end else if (!cs_fall && bit_take) begin
			tx_r <= frame_end ? reply_word : tx_shift;
		end
	end

	// miso: first bit at chip-select fall, the rest on falling edges
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			miso_r <= 1'b0;
		end else if (cs_fall) begin
			miso_r <= tx_r[15]; // first bit before first falling edge
		end else if (bit_give) begin
			miso_r <= tx_r[15]; // MSB first
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			page_r     <= IMUPS_RST_PAGE;
			pin_func_r <= IMUPS_RST_PIN_FUNC;
			pin_gen_r  <= IMUPS_RST_PIN_GEN;
		end else begin
			// any page number is taken; a page without registers reads zero except the page register at 0x00
			if (wr_page) begin
				page_r <= frame.data;
			end
			if (wr_pfunc) begin
				pin_func_r <= pfunc_nxt;
			end
			if (wr_pgen) begin
				pin_gen_r <= pgen_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs, all registered
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			miso_oe_r            <= 1'b0;
			o_general_pin_two    <= 1'b0;
			o_general_pin_two_oe <= 1'b0;
			o_ready              <= 1'b0;
			o_page               <= IMUPS_RST_PAGE;
		end else begin
			// miso driven only while selected, lagging chip-select
			miso_oe_r            <= active;
			// data-ready routed to pin two while enabled
			o_general_pin_two    <= pin_func_r[IMUPS_PF_DR_EN] & dr_r;
			o_general_pin_two_oe <= pin_func_r[IMUPS_PF_DR_EN];
			o_ready              <= (state_r == IMUPS_ST_RUN);
			o_page               <= page_r;
		end
	end

	assign o_spi_miso    = miso_r;
	assign o_spi_miso_oe = miso_oe_r;

endmodule : imups_port

`default_nettype wire

//--- rtl/imups_sync.sv
// imups two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module imups_sync (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	// async level in, synced level out
	input  wire logic i_async,
	output logic      o_sync
);

	logic meta_r;

	// ----------------------------------------------------------------
	// first flop read only by second
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			meta_r <= 1'b1;
			o_sync <= 1'b1;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule : imups_sync

`default_nettype wire

//--- tb/imups_host_model.sv
// imups host model: spi mode 3 master issuing 16-bit frames
`timescale 1ns/1ps
`default_nettype none
module imups_host_model (
	// core clock paces the serial clock
	input  wire logic i_core_clk,
	input  wire logic i_miso,
	input  wire logic i_miso_oe,
	// spi pins driven by the host
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_mosi
);
	// idle: clock high, deselected
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end
	// 400 ns serial period, eight core clocks: right at the port's limit
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
		@(posedge i_core_clk) #1 o_cs_n = 1'b0;
		repeat (4) @(posedge i_core_clk);
		for (int b = 15; b >= 0; b--) begin // all 16 clocks, msb first
			#1 o_sclk = 1'b0;
			o_mosi = tx[b];
			repeat (4) @(posedge i_core_clk);
			#1 o_sclk = 1'b1; // capture on the rising edge
			rx[b] = i_miso_oe ? i_miso : ~i_miso; // undriven line reads wrong
			repeat (4) @(posedge i_core_clk);
		end
		#1 o_cs_n = 1'b1;
		o_mosi = ~o_mosi; // released line: no stale bit left behind
		repeat (6) @(posedge i_core_clk);
	endtask : frame
endmodule : imups_host_model
`default_nettype wire

//--- tb/imups_port_properties.sv
// imups checker: port-level properties of the paged spi register port
`timescale 1ns/1ps
`default_nettype none
module imups_port_chk
	import imups_pkg::*;
#(
	parameter int INIT_CYCLES = IMUPS_INIT_CYC
) (
	// clock and reset
	input  wire logic          i_core_clk,
	input  wire logic          i_reset,
	// spi pins
	input  wire logic          i_spi_sclk,
	input  wire logic          i_spi_cs_n,
	input  wire logic          i_spi_mosi,
	input  wire logic          o_spi_miso,
	input  wire logic          o_spi_miso_oe,
	// samples, pins and status
	input  wire imups_sample_t i_sample,
	input  wire logic          i_sample_valid,
	input  wire logic          o_general_pin_two,
	input  wire logic          o_general_pin_two_oe,
	input  wire logic          o_ready,
	input  wire logic [7:0]    o_page
);
	// ----------------------------------------------------------------
	// startup wait counter, too long to unroll as a repetition
	// ----------------------------------------------------------------
	logic [15:0] wait_cnt_r;
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			wait_cnt_r <= 16'h0000;
		end else if (!o_ready) begin
			wait_cnt_r <= wait_cnt_r + 16'h0001;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	chk_start_page: assert property ($fell(i_reset) |-> o_page == 8'h00)
		else $error("page not zero after reset");
	chk_ready_bound: assert property (wait_cnt_r <= 16'(INIT_CYCLES + 4))
		else $error("startup took too long");
	chk_ready_hold: assert property (o_ready |=> o_ready)
		else $error("ready dropped while running");
	chk_drdy_pulse: assert property (o_general_pin_two |=> !o_general_pin_two)
		else $error("data-ready longer than one cycle");
	chk_drdy_cause: assert property ($rose(o_general_pin_two) |->
		$past(i_sample_valid) || $past(i_sample_valid, 2) || $past(i_sample_valid, 3))
		else $error("data-ready without a load");
	chk_drdy_route: assert property (o_general_pin_two |-> o_general_pin_two_oe)
		else $error("data-ready on undriven pin");
	chk_miso_settle: assert property ($rose(i_spi_sclk) && !i_spi_cs_n |=>
		$stable(o_spi_miso) [*2])
		else $error("miso moved after rising clock");
	chk_oe_frame: assert property ($fell(i_spi_cs_n) |-> ##[1:5] o_spi_miso_oe)
		else $error("miso not driven in frame");
	chk_oe_idle: assert property (i_spi_cs_n [*6] |-> !o_spi_miso_oe)
		else $error("miso driven while deselected");
endmodule : imups_port_chk

bind imups_port imups_port_chk #(.INIT_CYCLES(INIT_CYCLES)) u_imups_port_chk (
	.i_core_clk(i_core_clk), .i_reset(i_reset), .i_spi_sclk(i_spi_sclk),
	.i_spi_cs_n(i_spi_cs_n), .i_spi_mosi(i_spi_mosi), .o_spi_miso(o_spi_miso),
	.o_spi_miso_oe(o_spi_miso_oe), .i_sample(i_sample), .i_sample_valid(i_sample_valid),
	.o_general_pin_two(o_general_pin_two), .o_general_pin_two_oe(o_general_pin_two_oe),
	.o_ready(o_ready), .o_page(o_page)
);
`default_nettype wire

//--- tb/test_imups_port.sv
// imups testbench: paged register reads, writes and data-ready
`timescale 1ns/1ps
`default_nettype none
module test_imups_port
	import imups_pkg::*;
();
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic          core_clk, reset, sclk, cs_n, mosi, miso, miso_oe;
	logic          smp_valid, pin_two, pin_two_oe, ready;
	logic [7:0]    page;
	logic [15:0]   rx;
	imups_sample_t smp;
	int            n_fail;
	int            checked;

	imups_port #(.INIT_CYCLES(4)) u_imups_port (
		.i_core_clk(core_clk), .i_reset(reset), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
		.i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_sample(smp),
		.i_sample_valid(smp_valid), .o_general_pin_two(pin_two),
		.o_general_pin_two_oe(pin_two_oe), .o_ready(ready), .o_page(page)
	);
	imups_host_model u_imups_host_model (
		.i_core_clk(core_clk), .i_miso(miso), .i_miso_oe(miso_oe), .o_sclk(sclk),
		.o_cs_n(cs_n), .o_mosi(mosi)
	);

	// 20 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// distinct value per 16-bit slot, slot 0 at the top of the sample
	function automatic logic [15:0] slot_val(input int w);
		return 16'h9C40 + 16'(w * 273);
	endfunction : slot_val
	// page 0 address to slot: high words sit above low words
	function automatic int slot_of(input int a);
		if (a == 'h0E) return 17;
		if (a <= 'h26) return ((a - 'h10) / 4) * 2 + (((a & 2) != 0) ? 0 : 1);
		if (a <= 'h2C) return 12 + (a - 'h28) / 2;
		return (a == 'h30) ? 15 : 16;
	endfunction : slot_of

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one frame; its reply answers the frame before
	task automatic xfer(input logic [15:0] cmd, input logic [15:0] exp);
		u_imups_host_model.frame(cmd, rx);
		check(rx, exp);
	endtask : xfer
	// pulse a load, then look for the data-ready pulse
	task automatic load_watch(input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge core_clk) #1 smp_valid = 1'b1;
		@(posedge core_clk) #1 smp_valid = 1'b0;
		repeat (4) @(posedge core_clk) #1 seen = seen | pin_two;
		check({15'h0000, seen}, {15'h0000, exp});
	endtask : load_watch
	task automatic conclude;
		if (n_fail == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset = 1'b1;
		smp_valid = 1'b0;
		n_fail = 0;
		checked = 0;
		for (int w = 0; w < 18; w++) smp[$bits(smp) - 1 - 16 * w -: 16] = slot_val(w);
		repeat (8) @(posedge core_clk);
		#1 reset = 1'b0;
		for (int i = 0; i < 50 && ready !== 1'b1; i++) @(posedge core_clk);
		check({15'h0000, ready}, 16'h0001);
		if (ready !== 1'b1) conclude();
		check({8'h00, page}, 16'h0000);
		check({15'h0000, pin_two_oe}, 16'h0001);
		load_watch(1'b1);
		u_imups_host_model.frame(16'h0E00, rx);
		// pipelined sweep of page 0, junk in the low byte
		for (int a = 'h10; a <= 'h30; a += 2)
			xfer({1'b0, 7'(a), 8'hA5}, slot_val(slot_of(a - 2)));
		xfer(16'h7E00, slot_val(slot_of('h30)));
		xfer(16'h0000, 16'h0000); // unmapped word reads zero
		xfer(16'h1AFF, 16'h0000);
		xfer(16'h9A55, slot_val(4));
		xfer(16'h1A00, 16'h0000);
		xfer(16'h8003, slot_val(4)); // read-only word kept
		check({8'h00, page}, 16'h0003);
		xfer(16'h0600, 16'h0000);
		xfer(16'h0800, IMUPS_RST_PIN_FUNC);
		xfer(16'h8605, IMUPS_RST_PIN_GEN);
		check({15'h0000, pin_two_oe}, 16'h0000);
		load_watch(1'b0);
		xfer(16'h87A5, 16'h0000);
		xfer(16'h8809, 16'h0000);
		xfer(16'h0600, 16'h0000);
		xfer(16'h0800, 16'hA505);
		xfer(16'h8004, 16'h0009);
		check({8'h00, page}, 16'h0004);
		xfer(16'h2000, 16'h0000);
		xfer(16'h8000, IMUPS_SERIAL_VALUE);
		check({8'h00, page}, 16'h0000);
		xfer(16'h1A00, 16'h0000);
		xfer(16'h0000, slot_val(4));
		xfer(16'h8003, 16'h0000);
		check({8'h00, page}, 16'h0003);
		// mid-run reset: page and pin function return to their defaults
		@(posedge core_clk) #1 reset = 1'b1;
		repeat (8) @(posedge core_clk);
		#1 reset = 1'b0;
		for (int i = 0; i < 50 && ready !== 1'b1; i++) @(posedge core_clk);
		check({15'h0000, ready}, 16'h0001);
		if (ready !== 1'b1) conclude();
		check({8'h00, page}, 16'h0000);
		check({15'h0000, pin_two_oe}, 16'h0001);
		conclude();
	end
endmodule : test_imups_port
`default_nettype wire
